// [design/fieldbus_port_defines.svh]
// register offsets, field positions, reset values and timing figures of the port settings block
`ifndef FIELDBUS_PORT_DEFINES_SVH
`define FIELDBUS_PORT_DEFINES_SVH
`define REG_CTRL       8'h00
`define REG_ADDR       8'h04
`define REG_RATE       8'h08
`define REG_PARITY     8'h0C
`define REG_TIMEOUT    8'h10
`define REG_STATUS     8'h14
`define REG_DWORD_IN   8'h18
`define REG_DWORD_OUT  8'h1C
`define CTRL_KIND_LSB  0
`define CTRL_PERMIT    2
`define CTRL_ORDER     3
`define CTRL_RESTORE   4
`define SER_ADDR_MAX   8'hF7
`define SER_ADDR_DFLT  8'h01
`define PB_ADDR_MAX    8'h7D
`define PB_ADDR_DFLT   8'h7E
`define CA_ADDR_MAX    8'h7F
`define CA_ADDR_DFLT   8'h00
`define CB_ADDR_MAX    8'h3F
`define CB_ADDR_DFLT   8'h3F
`define SER_RATE_AUTO  16'h0005
`define PB_RATE_AUTO   16'hFFFF
`define CA_RATE_AUTO   16'h0008
`define CA_RATE_DFLT   16'h0009
`define CB_RATE_AUTO   16'h0003
`define CB_RATE_DFLT   16'h0000
`define TMO_MIN        16'h0001
`define TMO_MAX        16'h270F
`define TMO_DFLT       16'h00C8
`define ORDER_DFLT     1'b1
`define LOSS_UNIT_NS   1000000
`define CLK_PERIOD_NS  25
`endif

// [design/fieldbus_port_pkg.sv]
// types shared by the port settings block
package fieldbus_port_pkg;
  typedef enum logic [1:0] {
    KIND_SERIAL  = 2'h0,
    KIND_PROCESS = 2'h1,
    KIND_CAN_A   = 2'h2,
    KIND_CAN_B   = 2'h3
  } kind_e;
  typedef enum logic [1:0] {
    PAR_EVEN = 2'h0,
    PAR_ODD  = 2'h1,
    PAR_NONE = 2'h2
  } parity_e;
  typedef enum logic {
    HUNT   = 1'h0,
    LOCKED = 1'h1
  } hunt_e;
endpackage

// [design/fieldbus_port_settings.sv]
// network port settings: register file, validation, serial autodetect and comm-loss watch
//
// Functional notes
// - serial bus address 1..247 accepted; factory 1 means undefined
// - serial rate codes 1200..19200 baud or automatic; automatic is factory choice
// - serial automatic mode follows master, trying 19200 baud first
// - automatic mode also matches parity and stop bits, trying even first
// - in automatic mode stored parity is ignored, detected parity used
// - one stop bit with even or odd parity, two with none
// - timeout 1..9999 units; no master traffic within it declares comm loss
// - word order 0 puts low word first, 1 high word first; factory 1
// - process bus station address 1..125; factory value 126
// - process bus address 0 rejected; restore defaults sets 126
// - process bus rate only 0xFFFF, automatic adaptation; also factory value
// - permit cleared blocks network config writes, local writes still accepted
// - first CAN bus address 1..127; restore defaults sets invalid 0
// - first CAN rate codes 0..7 fixed speeds, 8 automatic, 9 means 250k
// - second CAN bus node id 0..63; factory 63
// - second CAN rate codes 0=125k factory, 1=250k, 2=500k, 3=automatic
// - no bus traffic joined while the node address is invalid
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "fieldbus_port_defines.svh"
module fieldbus_port_settings #(
  parameter int unsigned TICK_CYCLES = `LOSS_UNIT_NS / `CLK_PERIOD_NS
) (
  input  wire logic        aclk,          // 40 MHz clock
  input  wire logic        aresetn,       // synchronous reset, active low
  input  wire logic [7:0]  s_awaddr,      // write address
  input  wire logic        s_awvalid,     // write address valid
  output logic             s_awready,     // write address ready
  input  wire logic [31:0] s_wdata,       // write data
  input  wire logic [3:0]  s_wstrb,       // write byte strobes
  input  wire logic        s_wvalid,      // write data valid
  output logic             s_wready,      // write data ready
  output logic [1:0]       s_bresp,       // write response
  output logic             s_bvalid,      // write response valid
  input  wire logic        s_bready,      // write response ready
  input  wire logic [7:0]  s_araddr,      // read address
  input  wire logic        s_arvalid,     // read address valid
  output logic             s_arready,     // read address ready
  output logic [31:0]      s_rdata,       // read data
  output logic [1:0]       s_rresp,       // read response
  output logic             s_rvalid,      // read data valid
  input  wire logic        s_rready,      // read data ready
  input  wire logic        net_wr,        // config write arriving from the network, pulse
  input  wire logic [7:0]  net_wr_addr,   // its register offset
  input  wire logic [15:0] net_wr_data,   // its value
  input  wire logic        rx_frame_ok,   // receiver saw a good master frame, pulse
  input  wire logic        rx_frame_err,  // receiver saw a framing or parity error, pulse
  output logic [15:0]      link_speed,    // serial baud/100 (rate being tried in serial automatic), CAN kbaud, FFFF for process bus and CAN automatic
  output logic             link_auto,     // phy must adapt its rate to the master
  output logic [1:0]       link_parity,   // parity in use
  output logic             link_stop_two, // two stop bits
  output logic             link_join,     // node may take part in bus traffic
  output logic             comm_loss      // master silent beyond the timeout
);
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [1:0] RESP_DEC = 2'h3;
  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic addr_ok(input logic [1:0] k, input logic [7:0] a);
    unique case (fieldbus_port_pkg::kind_e'(k))
      fieldbus_port_pkg::KIND_SERIAL:  addr_ok = a > `SER_ADDR_DFLT && a <= `SER_ADDR_MAX;
      fieldbus_port_pkg::KIND_PROCESS: addr_ok = a != 8'h00 && a <= `PB_ADDR_MAX;
      fieldbus_port_pkg::KIND_CAN_A:   addr_ok = a != 8'h00 && a <= `CA_ADDR_MAX;
      fieldbus_port_pkg::KIND_CAN_B:   addr_ok = a <= `CB_ADDR_MAX;
    endcase
  endfunction

  // the serial factory address 1 is storable although it never lets the node join
  function automatic logic addr_storable(input logic [1:0] k, input logic [7:0] a);
    addr_storable = addr_ok(k, a) || (k == 2'h0 && a == `SER_ADDR_DFLT);
  endfunction

  function automatic logic rate_ok(input logic [1:0] k, input logic [15:0] r);
    unique case (fieldbus_port_pkg::kind_e'(k))
      fieldbus_port_pkg::KIND_SERIAL:  rate_ok = r <= `SER_RATE_AUTO;
      fieldbus_port_pkg::KIND_PROCESS: rate_ok = r == `PB_RATE_AUTO;
      fieldbus_port_pkg::KIND_CAN_A:   rate_ok = r <= `CA_RATE_DFLT;
      fieldbus_port_pkg::KIND_CAN_B:   rate_ok = r <= `CB_RATE_AUTO;
    endcase
  endfunction

  function automatic logic [15:0] serial_speed(input logic [2:0] c);
    unique case (c)
      3'h0:    serial_speed = 16'h000C;
      3'h1:    serial_speed = 16'h0018;
      3'h2:    serial_speed = 16'h0030;
      3'h3:    serial_speed = 16'h0060;
      default: serial_speed = 16'h00C0;
    endcase
  endfunction

  function automatic logic [15:0] can_a_speed(input logic [3:0] c);
    unique case (c)
      4'h0:    can_a_speed = 16'h000A;
      4'h1:    can_a_speed = 16'h0014;
      4'h2:    can_a_speed = 16'h0032;
      4'h3:    can_a_speed = 16'h007D;
      4'h5:    can_a_speed = 16'h01F4;
      4'h6:    can_a_speed = 16'h0320;
      4'h7:    can_a_speed = 16'h03E8;
      4'h8:    can_a_speed = 16'hFFFF;
      default: can_a_speed = 16'h00FA;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0]  kind_q, kind_d;
  logic        permit_q, permit_d, order_q, order_d;
  logic [7:0]  addr_q, addr_d;
  logic [15:0] rate_q, rate_d, tmo_q, tmo_d, unit_q, unit_d;
  logic [1:0]  par_q, par_d, cpar_q, cpar_d;
  logic [2:0]  crate_q, crate_d;
  logic [31:0] dword_q, dword_d, rdata_d;
  logic [23:0] tick_q, tick_d;
  fieldbus_port_pkg::hunt_e hunt_q, hunt_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic        awv_q, awv_d, wv_q, wv_d, bvalid_d, rvalid_d, loss_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic [1:0]  bresp_d, rresp_d;
  logic        join_d, auto_d, stop_d;
  logic [15:0] speed_d;
  logic [1:0]  lpar_d;
  logic        ser_auto, wen, wfrom_net, wbad, hit, restart;
  logic [7:0]  wsel;
  logic [31:0] wval, wold;

  // register read value for a given offset; also used to merge partial strobes
  function automatic logic [31:0] rd(input logic [7:0] a);
    unique case (a)
      `REG_CTRL:      rd = {28'h0000000, order_q, permit_q, kind_q};
      `REG_ADDR:      rd = {24'h000000, addr_q};
      `REG_RATE:      rd = {16'h0000, rate_q};
      `REG_PARITY:    rd = {30'h00000000, par_q};
      `REG_TIMEOUT:   rd = {16'h0000, tmo_q};
      `REG_STATUS:    rd = {22'h000000, link_stop_two, link_parity, crate_q, hunt_q, comm_loss,
                            link_join, addr_ok(kind_q, addr_q)};
      `REG_DWORD_IN:  rd = dword_q;
      `REG_DWORD_OUT: rd = order_q ? {dword_q[15:0], dword_q[31:16]} : dword_q;
      default:        rd = 32'h00000000;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = a[1:0] == 2'h0 && a <= `REG_DWORD_OUT;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    awaddr_d = awaddr_q;
    awv_d    = awv_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    wv_d     = wv_q;
    bvalid_d = s_bvalid && !s_bready;
    bresp_d  = s_bresp;
    rvalid_d = s_rvalid && !s_rready;
    rresp_d  = s_rresp;
    rdata_d  = s_rdata;
    if (s_awvalid && s_awready) begin
      awaddr_d = s_awaddr;
      awv_d    = 1'b1;
    end
    if (s_wvalid && s_wready) begin
      wdata_d = s_wdata;
      wstrb_d = s_wstrb;
      wv_d    = 1'b1;
    end
    // both halves of a local write present: apply it; a network write in the same cycle is dropped
    wen       = awv_q && wv_q && !s_bvalid;
    wfrom_net = 1'b0;
    wsel      = awaddr_q;
    wold      = rd(awaddr_q);
    for (int i = 0; i < 32; i++) begin
      wval[i] = wstrb_q[i / 8] ? wdata_q[i] : wold[i];
    end
    if (!wen && net_wr && permit_q) begin
      wen       = 1'b1;
      wfrom_net = 1'b1;
      wsel      = net_wr_addr;
      wval      = {16'h0000, net_wr_data};
    end
    kind_d   = kind_q;
    permit_d = permit_q;
    order_d  = order_q;
    addr_d   = addr_q;
    rate_d   = rate_q;
    par_d    = par_q;
    tmo_d    = tmo_q;
    dword_d  = dword_q;
    wbad     = !mapped(wsel);
    restart  = 1'b0;
    if (wen && !wbad) begin
      unique case (wsel)
        `REG_CTRL: begin
          kind_d   = wval[`CTRL_KIND_LSB +: 2];
          permit_d = wfrom_net ? permit_q : wval[`CTRL_PERMIT]; // network cannot lift its own block
          order_d  = wval[`CTRL_ORDER];
          if (wval[`CTRL_RESTORE] || kind_d != kind_q) begin
            restart = 1'b1;
            unique case (fieldbus_port_pkg::kind_e'(kind_d))
              fieldbus_port_pkg::KIND_SERIAL: begin
                addr_d = `SER_ADDR_DFLT;
                rate_d = `SER_RATE_AUTO;
              end
              fieldbus_port_pkg::KIND_PROCESS: begin
                addr_d = `PB_ADDR_DFLT;
                rate_d = `PB_RATE_AUTO;
              end
              fieldbus_port_pkg::KIND_CAN_A: begin
                addr_d = `CA_ADDR_DFLT;
                rate_d = `CA_RATE_DFLT;
              end
              fieldbus_port_pkg::KIND_CAN_B: begin
                addr_d = `CB_ADDR_DFLT;
                rate_d = `CB_RATE_DFLT;
              end
            endcase
          end
        end
        `REG_ADDR: begin
          wbad = !addr_storable(kind_q, wval[7:0]) || wval[31:8] != 24'h000000;
          if (!wbad) begin
            addr_d = wval[7:0];
          end
        end
        `REG_RATE: begin
          wbad = !rate_ok(kind_q, wval[15:0]) || wval[31:16] != 16'h0000;
          if (!wbad) begin
            rate_d  = wval[15:0];
            restart = 1'b1;
          end
        end
        `REG_PARITY: begin
          wbad = wval[31:0] > 32'h00000002;
          if (!wbad) begin
            par_d = wval[1:0];
          end
        end
        `REG_TIMEOUT: begin
          wbad = wval < {16'h0000, `TMO_MIN} || wval > {16'h0000, `TMO_MAX};
          if (!wbad) begin
            tmo_d = wval[15:0];
          end
        end
        `REG_DWORD_IN: dword_d = wval;
        default: wbad = 1'b1;
      endcase
    end
    if (wen && !wfrom_net) begin
      awv_d    = 1'b0;
      wv_d     = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = !mapped(awaddr_q) ? RESP_DEC : (wbad ? RESP_ERR : RESP_OK);
    end
    if (s_arvalid && s_arready) begin
      hit      = mapped(s_araddr);
      rvalid_d = 1'b1;
      rresp_d  = hit ? RESP_OK : RESP_DEC;
      rdata_d  = rd(s_araddr);
    end else begin
      hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial autodetect walks 19200 down to 1200, trying even, odd, none at each rate
  always_comb begin
    ser_auto = kind_q == 2'h0 && rate_q == `SER_RATE_AUTO;
    hunt_d   = hunt_q;
    crate_d  = crate_q;
    cpar_d   = cpar_q;
    if (!ser_auto || restart || comm_loss) begin
      hunt_d  = fieldbus_port_pkg::HUNT;
      crate_d = 3'h4;
      cpar_d  = fieldbus_port_pkg::PAR_EVEN;
    end else if (hunt_q == fieldbus_port_pkg::HUNT) begin
      if (rx_frame_ok) begin
        hunt_d = fieldbus_port_pkg::LOCKED;
      end else if (rx_frame_err) begin
        if (cpar_q == fieldbus_port_pkg::PAR_NONE) begin
          cpar_d  = fieldbus_port_pkg::PAR_EVEN;
          crate_d = crate_q == 3'h0 ? 3'h4 : 3'(crate_q - 3'h1);
        end else begin
          cpar_d = 2'(cpar_q + 2'h1);
        end
      end
    end
    // comm-loss watch runs only while the node is on the bus
    tick_d = tick_q;
    unit_d = unit_q;
    loss_d = comm_loss;
    if (!link_join || rx_frame_ok) begin
      tick_d = 24'h000000;
      unit_d = 16'h0000;
      loss_d = 1'b0;
    end else if (tick_q == TICK_LAST) begin
      tick_d = 24'h000000;
      // a timeout lowered below the running count must still end the wait
      if (unit_q >= 16'(tmo_q - 16'h0001)) begin
        loss_d = 1'b1;
      end else begin
        unit_d = 16'(unit_q + 16'h0001);
      end
    end else begin
      tick_d = 24'(tick_q + 24'h000001);
    end
    join_d = addr_ok(kind_q, addr_q);
    auto_d = ser_auto || kind_q == 2'h1 || (kind_q == 2'h2 && rate_q == `CA_RATE_AUTO)
             || (kind_q == 2'h3 && rate_q == `CB_RATE_AUTO);
    lpar_d = ser_auto ? cpar_q : par_q;
    stop_d = lpar_d == fieldbus_port_pkg::PAR_NONE;
    unique case (fieldbus_port_pkg::kind_e'(kind_q))
      fieldbus_port_pkg::KIND_SERIAL:  speed_d = serial_speed(ser_auto ? crate_q : rate_q[2:0]);
      fieldbus_port_pkg::KIND_PROCESS: speed_d = 16'hFFFF;
      fieldbus_port_pkg::KIND_CAN_A:   speed_d = can_a_speed(rate_q[3:0]);
      fieldbus_port_pkg::KIND_CAN_B:   speed_d = rate_q == 16'h0001 ? 16'h00FA
                                         : rate_q == 16'h0002 ? 16'h01F4
                                         : rate_q == `CB_RATE_AUTO ? 16'hFFFF : 16'h007D;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kind_q <= 2'h0;
      permit_q <= 1'b1;
      order_q <= `ORDER_DFLT;
      addr_q <= `SER_ADDR_DFLT;
      rate_q <= `SER_RATE_AUTO;
      par_q <= 2'h0;
      tmo_q <= `TMO_DFLT;
      dword_q <= 32'h00000000;
      hunt_q <= fieldbus_port_pkg::HUNT;
      crate_q <= 3'h4;
      cpar_q <= 2'h0;
      tick_q <= 24'h000000;
      unit_q <= 16'h0000;
      awaddr_q <= 8'h00;
      awv_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      wv_q <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
      s_rvalid <= 1'b0;
      s_rresp <= 2'h0;
      s_rdata <= 32'h00000000;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_arready <= 1'b0;
      comm_loss <= 1'b0;
      link_join <= 1'b0;
      link_auto <= 1'b0;
      link_parity <= 2'h0;
      link_stop_two <= 1'b0;
      link_speed <= 16'h0000;
    end else begin
      kind_q <= kind_d;
      permit_q <= permit_d;
      order_q <= order_d;
      addr_q <= addr_d;
      rate_q <= rate_d;
      par_q <= par_d;
      tmo_q <= tmo_d;
      dword_q <= dword_d;
      hunt_q <= hunt_d;
      crate_q <= crate_d;
      cpar_q <= cpar_d;
      tick_q <= tick_d;
      unit_q <= unit_d;
      awaddr_q <= awaddr_d;
      awv_q <= awv_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      wv_q <= wv_d;
      s_bvalid <= bvalid_d;
      s_bresp <= bresp_d;
      s_rvalid <= rvalid_d;
      s_rresp <= rresp_d;
      s_rdata <= rdata_d;
      s_awready <= !awv_d && !bvalid_d;
      s_wready <= !wv_d && !bvalid_d;
      s_arready <= !rvalid_d;
      comm_loss <= loss_d;
      link_join <= join_d;
      link_auto <= auto_d;
      link_parity <= lpar_d;
      link_stop_two <= stop_d;
      link_speed <= speed_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // link_join lags the registers by one cycle, so it is judged against last cycle's kind
  AST_SER_ADDR_RANGE: assert property (
      link_join && $past(kind_q) == 2'h0 |-> $past(addr_q) >= 8'h02 && $past(addr_q) <= 8'hF7)
    else $error("serial join with bad address");
  AST_HUNT_START: assert property ($rose(ser_auto) |-> crate_q == 3'h4 && cpar_q == 2'h0)
    else $error("hunt did not start at 19200 even");
  AST_HUNT_STEP: assert property (
      ser_auto && hunt_q == fieldbus_port_pkg::HUNT && !restart && !comm_loss && rx_frame_err
      && !rx_frame_ok && cpar_q == 2'h0 |=> cpar_q == 2'h1 && $stable(crate_q))
    else $error("parity not stepped after even");
  AST_AUTO_PARITY: assert property (ser_auto |=> link_parity == $past(cpar_q))
    else $error("stored parity used in autodetect");
  AST_STOP_BITS: assert property (link_stop_two == (link_parity == 2'h2))
    else $error("stop bits do not follow parity");
  AST_TMO_RANGE: assert property (tmo_q >= 16'h0001 && tmo_q <= 16'h270F)
    else $error("timeout out of range");
  AST_PB_RATE: assert property (
      kind_q == 2'h1 && $stable(kind_q) |-> rate_q == 16'hFFFF)
    else $error("process rate not automatic");
  AST_NET_BLOCK: assert property (
      !permit_q && net_wr && !wen |=> $stable(addr_q) && $stable(rate_q) && $stable(tmo_q))
    else $error("network write passed while blocked");
  AST_JOIN_VALID: assert property (!addr_ok(kind_q, addr_q) |=> !link_join)
    else $error("joined with invalid address");
  AST_BAD_KEEP: assert property (
      $rose(s_bvalid) && s_bresp == 2'h2 |-> $stable(addr_q) && $stable(rate_q) && $stable(tmo_q))
    else $error("rejected write changed a value");
  COV_LOCK: cover property (ser_auto && hunt_q == fieldbus_port_pkg::HUNT
      ##1 hunt_q == fieldbus_port_pkg::LOCKED);
  COV_LOSS: cover property ($rose(comm_loss));
  COV_REJECT: cover property (s_bvalid && s_bresp == 2'h2);
  COV_NET_WRITE: cover property (net_wr && permit_q && !(awv_q && wv_q));
endmodule
`default_nettype wire

// [sim/fieldbus_master_model.sv]
// far-side master and receiver: a frame decodes only when the port framing matches the master
`timescale 1ns/100ps
`default_nettype none
module fieldbus_master_model (
  input  wire logic        aclk,          // port clock
  input  wire logic        aresetn,       // synchronous reset, active low
  input  wire logic        send,          // master puts one frame on the line, pulse
  input  wire logic [15:0] m_speed,       // master rate, link_speed scale
  input  wire logic [1:0]  m_parity,      // master parity
  input  wire logic [15:0] link_speed,    // port rate in use
  input  wire logic [1:0]  link_parity,   // port parity in use
  input  wire logic        link_stop_two, // port stop bits
  output logic             rx_frame_ok,   // frame decoded
  output logic             rx_frame_err   // framing or parity error
);
  logic match;
  // the master talks only on a send pulse, in every port mode, so rate hunting has traffic only when the bench sends a frame
  assign match = link_speed == m_speed && link_parity == m_parity
                 && link_stop_two == (m_parity == 2'h2);
  always_ff @(posedge aclk) begin
    rx_frame_ok  <= aresetn && send && match;
    rx_frame_err <= aresetn && send && !match;
  end
endmodule
`default_nettype wire

// [sim/fieldbus_port_settings_test.sv]
// self-checking bench of the network port settings block
`timescale 1ns/100ps
`default_nettype none
`include "fieldbus_port_defines.svh"
module fieldbus_port_settings_test;
  logic aclk = 1'b0, aresetn = 1'b0, s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0, net_wr = 1'b0, send = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00, net_wr_addr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'hF;
  logic [15:0] net_wr_data = 16'h0, m_speed = 16'h0, link_speed;
  logic [1:0] m_parity = 2'h0, s_bresp, s_rresp, link_parity;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, link_auto, link_stop_two;
  logic link_join, comm_loss, rx_frame_ok, rx_frame_err;
  logic [31:0] s_rdata;
  logic [31:0] shadow [8] = '{32'hC, 32'h1, 32'h5, 32'h0, 32'hC8, 32'h0, 32'h0, 32'h0};
  logic [7:0] amin [4] = '{8'h01, 8'h01, 8'h01, 8'h00};
  logic [7:0] jmin [4] = '{8'h02, 8'h01, 8'h01, 8'h00};
  logic [7:0] amax [4] = '{8'hF7, 8'h7D, 8'h7F, 8'h3F};
  logic [7:0] adflt [4] = '{8'h01, 8'h7E, 8'h00, 8'h3F};
  logic [15:0] rdflt [4] = '{16'h5, 16'hFFFF, 16'h9, 16'h0};
  logic [15:0] acode [4] = '{16'h5, 16'hFFFF, 16'h8, 16'h3};
  logic [3:0] rmax [4] = '{4'h5, 4'h0, 4'h9, 4'h3};
  logic [15:0] ser_spd [6] = '{16'h0C, 16'h18, 16'h30, 16'h60, 16'hC0, 16'hC0};
  logic [15:0] cana_spd [10] = '{16'h0A, 16'h14, 16'h32, 16'h7D, 16'hFA, 16'h1F4, 16'h320,
                                 16'h3E8, 16'hFFFF, 16'hFA};
  logic [15:0] canb_spd [4] = '{16'h7D, 16'hFA, 16'h1F4, 16'hFFFF};
  logic [15:0] lfsr = 16'hCCBA;
  int n_errors = 0, comparisons = 0, cycles = 0;
  fieldbus_port_settings #(.TICK_CYCLES(4)) fieldbus_port_settings_i (
    .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .net_wr, .net_wr_addr, .net_wr_data, .rx_frame_ok,
    .rx_frame_err, .link_speed, .link_auto, .link_parity, .link_stop_two, .link_join,
    .comm_loss);
  fieldbus_master_model fieldbus_master_model_i (
    .aclk, .aresetn, .send, .m_speed, .m_parity, .link_speed, .link_parity, .link_stop_two,
    .rx_frame_ok, .rx_frame_err);
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic logic [1:0] resp(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] k;
    k = shadow[0][1:0];
    if (a > `REG_DWORD_OUT || a[1:0] != 2'h0) return 2'h3;
    case (a)
      `REG_ADDR: return (d >= amin[k] && d <= amax[k]) ? 2'h0 : 2'h2;
      `REG_RATE: return ((k == 2'h1) ? d == 32'hFFFF : d <= rmax[k]) ? 2'h0 : 2'h2;
      `REG_PARITY: return (d <= 32'h2) ? 2'h0 : 2'h2;
      `REG_TIMEOUT: return (d >= 32'h1 && d <= 32'h270F) ? 2'h0 : 2'h2;
      `REG_STATUS, `REG_DWORD_OUT: return 2'h2;
      default: return 2'h0;
    endcase
  endfunction
  function automatic logic jexp();
    return shadow[1] >= jmin[shadow[0][1:0]] && shadow[1] <= amax[shadow[0][1:0]];
  endfunction
  function automatic logic [15:0] spd(input int k, input logic [31:0] c);
    case (k)
      0: return ser_spd[c[2:0]];
      1: return 16'hFFFF;
      2: return cana_spd[c[3:0]];
      default: return canb_spd[c[1:0]];
    endcase
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] e;
    e = resp(a, d);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
    chk("bresp", e, s_bresp);
    if (e == 2'h0 && a == `REG_CTRL && (d[1:0] != shadow[0][1:0] || d[4])) begin
      shadow[1] = adflt[d[1:0]];
      shadow[2] = rdflt[d[1:0]];
    end
    if (e == 2'h0) shadow[a[4:2]] = (a == `REG_CTRL) ? d & 32'hF : d;
    repeat (3) @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rdx(input logic [7:0] a);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("rresp", 2'h0, r);
    chk("rdata", shadow[a[4:2]], d);
  endtask
  task automatic frame();
    send <= 1'b1;
    @(posedge aclk);
    send <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    logic [31:0] v, d;
    logic [1:0] r;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 5; i++) rdx(8'(i * 4));
    chk("speed", 16'hC0, link_speed);
    chk("join", 1'b0, link_join);
    rd(8'h20, d, r);
    chk("unmapped", 2'h3, r);
    wr(`REG_STATUS, 32'h0);
    $display("test reset done");
    for (int k = 3; k >= 0; k--) begin
      wr(`REG_CTRL, 32'(k) | 32'hC);
      rdx(`REG_ADDR);
      rdx(`REG_RATE);
      chk("join", jexp(), link_join);
      for (int c = 0; c < 11; c++) begin
        v = (k == 1 && c == 10) ? 32'hFFFF : 32'(c);
        wr(`REG_RATE, v);
        chk("speed", spd(k, shadow[2]), link_speed);
        chk("auto", shadow[2] == acode[k], link_auto);
      end
      wr(`REG_ADDR, 32'h0);
      wr(`REG_ADDR, 32'(amax[k]) + 32'h1);
      wr(`REG_ADDR, 32'(amax[k]));
      chk("join", jexp(), link_join);
      wr(`REG_CTRL, 32'(k) | 32'h1C);
      rdx(`REG_ADDR);
      chk("join", jexp(), link_join);
    end
    $display("test kinds done");
    wr(`REG_ADDR, 32'(rnd() % 16'hF6) + 32'h2);
    chk("join", 1'b1, link_join);
    wr(`REG_RATE, 32'h3);
    for (int p = 0; p < 4; p++) begin
      wr(`REG_PARITY, 32'(p));
      chk("parity", shadow[3][1:0], link_parity);
      chk("stop", shadow[3] == 32'h2, link_stop_two);
    end
    $display("test framing done");
    wr(`REG_TIMEOUT, 32'h0);
    wr(`REG_TIMEOUT, 32'h2710);
    wr(`REG_TIMEOUT, 32'h2);
    rdx(`REG_TIMEOUT);
    m_speed <= 16'h60;
    m_parity <= 2'h2;
    frame();
    chk("loss", 1'b0, comm_loss);
    repeat (12) @(posedge aclk);
    chk("loss", 1'b1, comm_loss);
    $display("test comm loss done");
    // a long timeout keeps comm loss from restarting the hunt while it runs
    wr(`REG_TIMEOUT, 32'h64);
    frame();
    m_speed <= 16'h30;
    m_parity <= 2'h1;
    wr(`REG_RATE, 32'h5);
    chk("speed", 16'hC0, link_speed);
    chk("parity", 2'h0, link_parity);
    repeat (10) frame();
    chk("speed", 16'h30, link_speed);
    chk("parity", 2'h1, link_parity);
    chk("stop", 1'b0, link_stop_two);
    rd(`REG_STATUS, d, r);
    chk("locked", 1'b1, d[3]);
    $display("test autodetect done");
    v = {rnd(), rnd()};
    wr(`REG_DWORD_IN, v);
    rd(`REG_DWORD_OUT, d, r);
    chk("dword", {v[15:0], v[31:16]}, d);
    wr(`REG_CTRL, 32'h4);
    rd(`REG_DWORD_OUT, d, r);
    chk("dword", v, d);
    $display("test word order done");
    for (int i = 0; i < 2; i++) begin
      net_wr <= 1'b1;
      net_wr_addr <= `REG_ADDR;
      net_wr_data <= 16'h10 + 16'(i);
      @(posedge aclk);
      net_wr <= 1'b0;
      if (shadow[0][2]) shadow[1] = 32'h10 + 32'(i);
      repeat (3) @(posedge aclk);
      rdx(`REG_ADDR);
      wr(`REG_CTRL, 32'h0);
    end
    $display("test permit done");
    wrap_up();
  end
endmodule
`default_nettype wire
